// ===== src/svotl_pkg.sv
package svotl_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int NS_PER_MS = 1000000;
    localparam int CYC_PER_MS_DEF = NS_PER_MS / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_INT_FWD = 8'h04;
    localparam logic [7:0] A_INT_REV = 8'h08;
    localparam logic [7:0] A_EXT1 = 8'h0c;
    localparam logic [7:0] A_EXT2 = 8'h10;
    localparam logic [7:0] A_ESTOP = 8'h14;
    localparam logic [7:0] A_MMAX = 8'h18;
    localparam logic [7:0] A_UV_LIM = 8'h1c;
    localparam logic [7:0] A_UV_REL = 8'h20;
    localparam logic [7:0] A_WARN_PCT = 8'h24;
    localparam logic [7:0] A_DERATE = 8'h28;
    localparam logic [7:0] A_WARN_CUR = 8'h2c;
    localparam logic [7:0] A_STATUS = 8'h30;
    localparam logic [7:0] A_MASK = 8'h34;
    localparam logic [7:0] A_STATE = 8'h38;

    // Control register fields
    localparam int C_METHOD_LSB = 0;
    localparam int C_SUP400 = 3;
    localparam int C_UVF_LSB = 4;
    localparam int C_OVL_CLR = 8;

    // Reset values and ranges, in percent unless noted
    localparam logic [2:0] METHOD_RST = 3'h2;
    localparam logic [2:0] METHOD_MAX = 3'h5;
    localparam logic [9:0] LIM_RST = 10'h12c;
    localparam logic [9:0] PCT_MAX = 10'h1f4;
    localparam logic [9:0] ESTOP_RST = 10'h320;
    localparam logic [9:0] ESTOP_MAX = 10'h320;
    localparam logic [9:0] UV_LIM_RST = 10'h032;
    localparam logic [9:0] UV_LIM_MAX = 10'h064;
    localparam logic [9:0] REL_MS_RST = 10'h064;
    localparam logic [9:0] REL_MS_MAX = 10'h3e8;
    localparam logic [9:0] WARN_PCT_RST = 10'h014;
    localparam logic [9:0] DERATE_RST = 10'h064;
    localparam logic [9:0] DERATE_NONE = 10'h064;
    localparam logic [9:0] WARN_CUR_RST = 10'h073;
    localparam logic [1:0] UVF_OFF = 2'h0;
    localparam logic [1:0] UVF_WARN = 2'h1;
    localparam logic [1:0] UVF_LIMIT = 2'h2;

    // Overload curve points
    localparam logic [9:0] OVL_START_PCT = 10'h073;
    localparam logic [9:0] MOTOR_KNEE_PCT = 10'h0b4;
    localparam logic [9:0] DRIVE_KNEE_PCT = 10'h0aa;
    localparam int OVL_INST_GAIN = 4;
    localparam logic [31:0] OVL_ALARM_LVL_DEF = 32'h0098_9680;

    // Bus voltage levels in volts
    localparam logic [9:0] UV_DET_200 = 10'h0c8;
    localparam logic [9:0] UV_REL_200 = 10'h118;
    localparam logic [9:0] UV_DET_400 = 10'h190;
    localparam logic [9:0] UV_REL_400 = 10'h230;

    typedef enum logic [1:0] {UV_IDLE, UV_HOLD, UV_RAMP} svotl_uv_t;

    function automatic logic [31:0] pct_of(logic [31:0] v, logic [9:0] p);
        logic [41:0] prod;
        prod = {10'h0, v} * {32'h0, p};
        pct_of = 32'(prod / 42'h64);
    endfunction

    function automatic logic [9:0] min2(logic [9:0] a, logic [9:0] b);
        min2 = (a < b) ? a : b;
    endfunction

    function automatic logic [9:0] sat10(logic [31:0] v, logic [9:0] mx);
        sat10 = (v > {22'h0, mx}) ? mx : v[9:0];
    endfunction

endpackage

// ===== src/svotl_ovl.sv
module svotl_ovl
    import svotl_pkg::*;
#(
    parameter logic [9:0] KNEE_PCT = MOTOR_KNEE_PCT,
    parameter int GAIN = OVL_INST_GAIN
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    // Load and settings
    input wire logic [9:0] cur,
    input wire logic [9:0] derate,
    input wire logic [9:0] warn_pct,
    input wire logic [9:0] warn_cur,
    input wire logic [31:0] alarm_lvl,
    // Results
    output logic warn,
    output logic alarm
);
    typedef struct packed {
        logic [31:0] acc_a;
        logic [31:0] acc_w;
        logic warn;
        logic alarm;
    } svotl_ovl_t;

    svotl_ovl_t s;
    svotl_ovl_t n;
    logic [9:0] start;
    logic [31:0] wlvl;

    // Accumulate excess load, faster past the knee, leak when below start
    function automatic logic [31:0] step(logic [31:0] acc, logic [9:0] c,
                                         logic [9:0] st);
        logic [31:0] inc;
        logic [32:0] sum;
        inc = 32'h0;
        sum = 33'h0;
        if (c > st) begin
            inc = {22'h0, c - st};
            if (c > KNEE_PCT) begin
                inc = 32'(inc * GAIN);
            end
            sum = {1'b0, acc} + {1'b0, inc};
            step = sum[32] ? 32'hffff_ffff : sum[31:0];
        end else begin
            step = (acc != 32'h0) ? acc - 32'h1 : acc;
        end
    endfunction

    always_comb begin
        n = s;
        start = 10'(pct_of({22'h0, OVL_START_PCT}, derate));
        wlvl = pct_of(alarm_lvl, warn_pct);
        n.acc_a = step(s.acc_a, cur, start);
        n.acc_w = step(s.acc_w, cur, warn_cur);
        if (clr) begin
            n.acc_a = 32'h0;
            n.acc_w = 32'h0;
        end
        n.warn = n.acc_w >= wlvl;
        n.alarm = (clr ? 1'b0 : s.alarm) | (n.acc_a >= alarm_lvl);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= n;
        end
    end

    assign warn = s.warn;
    assign alarm = s.alarm;

    a_acc_idle: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !clr && cur <= start && s.acc_a == 32'h0) |=> s.acc_a == 32'h0
    ) else $error("Overload accumulated below start current");

    a_alarm_trip: assert property (
        @(posedge clk) disable iff (rst)
        (ce && !clr && s.acc_a >= alarm_lvl) |=> alarm
    ) else $error("Overload alarm missed at level");

endmodule

// ===== src/svotl_top.sv
// Function
// - Warning time defaults to 20% of alarm
// - Warning percent scales warning detection time
// - Motor base current is 1.15 rated times derating
// - Warning current sets motor warning accumulation start
// - Motor curve starts 115%, knee 180%
// - Drive curve starts 115%, knee 170%
// - Limit method selector 0 to 5, default 2
// - Four torque limits 0-500%, default 300%
// - Clamp limits to motor maximum torque
// - Torque limited flag high while limiting
// - Undervoltage warning when bus below threshold
// - Mode 0 off, 1 warn, 2 warn+limit
// - Undervoltage limit 0-100%, default 50%
// - Release time 0-1000 ms, default 100
// - 200 V supply: detect 200, release 280
// - 400 V supply: detect 400, release 560
module svotl_top
    import svotl_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF,
    parameter logic [31:0] OVL_ALARM_LVL = OVL_ALARM_LVL_DEF
) (
    // Clock, reset and enable
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Drive measurements and command
    input wire logic signed [11:0] TORQUE_CMD,
    input wire logic [9:0] MOTOR_CUR,
    input wire logic [9:0] DRIVE_CUR,
    input wire logic [9:0] DC_BUS_V,
    input wire logic EXT_FWD_SEL,
    input wire logic EXT_REV_SEL,
    input wire logic EMERG_STOP,
    // Torque and status
    output logic signed [11:0] TORQUE_OUT,
    output logic TORQUE_LIMITED,
    output logic UV_WARN,
    output logic MOTOR_OVL_WARN,
    output logic MOTOR_OVL_ALARM,
    output logic DRIVE_OVL_WARN,
    output logic DRIVE_OVL_ALARM,
    output logic IRQ
);
    typedef struct packed {
        logic [2:0] method;
        logic sup400;
        logic [1:0] uv_func;
        logic [9:0] int_fwd;
        logic [9:0] int_rev;
        logic [9:0] ext1;
        logic [9:0] ext2;
        logic [9:0] estop;
        logic [9:0] mmax;
        logic [9:0] uv_lim;
        logic [9:0] rel_ms;
        logic [9:0] warn_pct;
        logic [9:0] derate;
        logic [9:0] warn_cur;
        logic [5:0] sts;
        logic [5:0] mask;
        logic [5:0] prev;
        svotl_uv_t uv_st;
        logic uv_warn;
        logic [9:0] ramp_lim;
        logic [9:0] ramp_diff;
        logic [31:0] ramp_acc;
        logic [31:0] ramp_t;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic ovl_clr;
        logic signed [11:0] tout;
        logic torque_limited_flag;
        logic irq;
    } svotl_top_t;

    localparam svotl_top_t RESET_S = '{
        method: METHOD_RST,
        int_fwd: LIM_RST,
        int_rev: LIM_RST,
        ext1: LIM_RST,
        ext2: LIM_RST,
        estop: ESTOP_RST,
        mmax: LIM_RST,
        uv_lim: UV_LIM_RST,
        rel_ms: REL_MS_RST,
        warn_pct: WARN_PCT_RST,
        derate: DERATE_RST,
        warn_cur: WARN_CUR_RST,
        uv_func: UVF_OFF,
        uv_st: UV_IDLE,
        default: '0
    };

    svotl_top_t s;
    svotl_top_t n;
    logic m_warn;
    logic m_alarm;
    logic d_warn;
    logic d_alarm;
    logic [9:0] sel_f;
    logic [9:0] sel_r;
    logic [9:0] uvl;
    logic [9:0] cap;
    logic [9:0] lim_f;
    logic [9:0] lim_r;
    logic [9:0] det;
    logic [9:0] rel;
    logic [5:0] live;
    logic [5:0] ev;
    logic [5:0] sts_keep;
    logic [31:0] rd;
    logic [31:0] acc;
    logic hit;
    logic access;
    logic done;

    // Overload detectors for motor and drive
    svotl_ovl #(
        .KNEE_PCT(MOTOR_KNEE_PCT),
        .GAIN(OVL_INST_GAIN)
    ) u_motor (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .clr(s.ovl_clr),
        .cur(MOTOR_CUR),
        .derate(s.derate),
        .warn_pct(s.warn_pct),
        .warn_cur(s.warn_cur),
        .alarm_lvl(OVL_ALARM_LVL),
        .warn(m_warn),
        .alarm(m_alarm)
    );

    svotl_ovl #(
        .KNEE_PCT(DRIVE_KNEE_PCT),
        .GAIN(OVL_INST_GAIN)
    ) u_drive (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .clr(s.ovl_clr),
        .cur(DRIVE_CUR),
        .derate(DERATE_NONE),
        .warn_pct(s.warn_pct),
        .warn_cur(OVL_START_PCT),
        .alarm_lvl(OVL_ALARM_LVL),
        .warn(d_warn),
        .alarm(d_alarm)
    );

    always_comb begin
        n = s;
        acc = 32'h0;
        // Limit source by method
        case (s.method)
            3'h0: begin
                sel_f = s.int_fwd;
                sel_r = s.int_rev;
            end
            3'h1: begin
                sel_f = s.ext1;
                sel_r = s.ext2;
            end
            3'h2: begin
                sel_f = EXT_FWD_SEL ? min2(s.int_fwd, s.ext1) : s.int_fwd;
                sel_r = EXT_REV_SEL ? min2(s.int_rev, s.ext2) : s.int_rev;
            end
            3'h3: begin
                sel_f = min2(s.int_fwd, s.ext1);
                sel_r = min2(s.int_rev, s.ext2);
            end
            3'h4: begin
                sel_f = s.ext1;
                sel_r = s.ext1;
            end
            default: begin
                sel_f = PCT_MAX;
                sel_r = PCT_MAX;
            end
        endcase
        uvl = (s.uv_st == UV_IDLE) ? PCT_MAX : s.ramp_lim;
        if (s.uv_st == UV_HOLD) begin
            uvl = s.uv_lim;
        end
        cap = EMERG_STOP ? min2(s.mmax, s.estop) : s.mmax;
        lim_f = min2(min2(sel_f, uvl), cap);
        lim_r = min2(min2(sel_r, uvl), cap);

        // Torque clamp and limited flag
        n.tout = TORQUE_CMD;
        n.torque_limited_flag = 1'b0;
        if (TORQUE_CMD > $signed({2'h0, lim_f})) begin
            n.tout = $signed({2'h0, lim_f});
            n.torque_limited_flag = 1'b1;
        end else if (TORQUE_CMD < -$signed({2'h0, lim_r})) begin
            n.tout = -$signed({2'h0, lim_r});
            n.torque_limited_flag = 1'b1;
        end

        // Undervoltage detection with hysteresis
        det = s.sup400 ? UV_DET_400 : UV_DET_200;
        rel = s.sup400 ? UV_REL_400 : UV_REL_200;
        if (s.uv_func == UVF_OFF) begin
            n.uv_warn = 1'b0;
        end else if (DC_BUS_V < det) begin
            n.uv_warn = 1'b1;
        end else if (DC_BUS_V >= rel) begin
            n.uv_warn = 1'b0;
        end

        // Undervoltage limit hold and release ramp
        case (s.uv_st)
            UV_IDLE: begin
                if (s.uv_warn && s.uv_func == UVF_LIMIT) begin
                    n.uv_st = UV_HOLD;
                    n.ramp_lim = s.uv_lim;
                end
            end
            UV_HOLD: begin
                n.ramp_lim = s.uv_lim;
                if (!s.uv_warn) begin
                    n.ramp_acc = 32'h0;
                    n.ramp_t = 32'(s.rel_ms) * 32'(CYC_PER_MS);
                    n.ramp_diff = (s.mmax > s.uv_lim) ? s.mmax - s.uv_lim
                                                      : 10'h0;
                    if (s.rel_ms == 10'h0 || s.mmax <= s.uv_lim) begin
                        n.uv_st = UV_IDLE;
                    end else begin
                        n.uv_st = UV_RAMP;
                    end
                end
            end
            UV_RAMP: begin
                if (s.uv_warn) begin
                    n.uv_st = UV_HOLD;
                    n.ramp_lim = s.uv_lim;
                end else begin
                    acc = s.ramp_acc + {22'h0, s.ramp_diff};
                    if (acc >= s.ramp_t) begin
                        n.ramp_acc = acc - s.ramp_t;
                        n.ramp_lim = s.ramp_lim + 10'h1;
                        if (s.ramp_lim + 10'h1 >= s.mmax) begin
                            n.uv_st = UV_IDLE;
                        end
                    end else begin
                        n.ramp_acc = acc;
                    end
                end
            end
            default: begin
                n.uv_st = UV_IDLE;
            end
        endcase

        // Rising edges of status become sticky events
        live = {s.torque_limited_flag, s.uv_warn, d_alarm, d_warn, m_alarm, m_warn};
        ev = live & ~s.prev;
        n.prev = live;

        // Register read decode
        hit = 1'b1;
        rd = 32'h0;
        case (PADDR)
            A_CTRL: rd = {26'h0, s.uv_func, s.sup400, s.method};
            A_INT_FWD: rd = {22'h0, s.int_fwd};
            A_INT_REV: rd = {22'h0, s.int_rev};
            A_EXT1: rd = {22'h0, s.ext1};
            A_EXT2: rd = {22'h0, s.ext2};
            A_ESTOP: rd = {22'h0, s.estop};
            A_MMAX: rd = {22'h0, s.mmax};
            A_UV_LIM: rd = {22'h0, s.uv_lim};
            A_UV_REL: rd = {22'h0, s.rel_ms};
            A_WARN_PCT: rd = {22'h0, s.warn_pct};
            A_DERATE: rd = {22'h0, s.derate};
            A_WARN_CUR: rd = {22'h0, s.warn_cur};
            A_STATUS: rd = {26'h0, s.sts};
            A_MASK: rd = {26'h0, s.mask};
            A_STATE: rd = {4'h0, lim_r, lim_f,
                           s.uv_st == UV_RAMP, s.uv_st != UV_IDLE, live};
            default: hit = 1'b0;
        endcase

        // APB handshake, one wait state
        access = PSEL && PENABLE && !s.pready;
        done = PSEL && PENABLE && s.pready;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.ovl_clr = 1'b0;
        if (access) begin
            n.pready = 1'b1;
            n.pslverr = !hit;
            n.prdata = PWRITE ? 32'h0 : rd;
        end

        // Status clears on read, a new event wins
        sts_keep = s.sts;
        if (done && !PWRITE && PADDR == A_STATUS) begin
            sts_keep = 6'h0;
        end
        n.sts = sts_keep | ev;

        if (done && PWRITE && hit) begin
            case (PADDR)
                A_CTRL: begin
                    if (PWDATA[C_METHOD_LSB +: 3] <= METHOD_MAX) begin
                        n.method = PWDATA[C_METHOD_LSB +: 3];
                    end
                    n.sup400 = PWDATA[C_SUP400];
                    if (PWDATA[C_UVF_LSB +: 2] <= UVF_LIMIT) begin
                        n.uv_func = PWDATA[C_UVF_LSB +: 2];
                    end
                    n.ovl_clr = PWDATA[C_OVL_CLR];
                end
                A_INT_FWD: n.int_fwd = sat10(PWDATA, PCT_MAX);
                A_INT_REV: n.int_rev = sat10(PWDATA, PCT_MAX);
                A_EXT1: n.ext1 = sat10(PWDATA, PCT_MAX);
                A_EXT2: n.ext2 = sat10(PWDATA, PCT_MAX);
                A_ESTOP: n.estop = sat10(PWDATA, ESTOP_MAX);
                A_MMAX: n.mmax = sat10(PWDATA, PCT_MAX);
                A_UV_LIM: n.uv_lim = sat10(PWDATA, UV_LIM_MAX);
                A_UV_REL: n.rel_ms = sat10(PWDATA, REL_MS_MAX);
                A_WARN_PCT: n.warn_pct = sat10(PWDATA, UV_LIM_MAX);
                A_DERATE: n.derate = sat10(PWDATA, UV_LIM_MAX);
                A_WARN_CUR: n.warn_cur = sat10(PWDATA, PCT_MAX);
                A_MASK: n.mask = PWDATA[5:0];
                default: n.mask = s.mask;
            endcase
        end
        n.irq = |(n.sts & n.mask);
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s <= RESET_S;
        end else if (CE) begin
            s <= n;
        end
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign TORQUE_OUT = s.tout;
    assign TORQUE_LIMITED = s.torque_limited_flag;
    assign UV_WARN = s.uv_warn;
    assign MOTOR_OVL_WARN = m_warn;
    assign MOTOR_OVL_ALARM = m_alarm;
    assign DRIVE_OVL_WARN = d_warn;
    assign DRIVE_OVL_ALARM = d_alarm;
    assign IRQ = s.irq;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    a_tlt_level: assert property (
        (CE && TORQUE_CMD > $signed({2'h0, lim_f})) |=> TORQUE_LIMITED
    ) else $error("Limited flag missing on clamp");

    a_tout_clamp: assert property (
        (CE && TORQUE_CMD > $signed({2'h0, lim_f}))
        |=> TORQUE_OUT == $signed({2'h0, $past(lim_f)})
    ) else $error("Torque not clamped to forward limit");

    a_eff_min: assert property (
        lim_f <= s.mmax && lim_f <= sel_f && lim_r <= uvl
    ) else $error("Effective limit above a source limit");

    a_uv_detect: assert property (
        (CE && s.uv_func != UVF_OFF && DC_BUS_V < det) |=> UV_WARN
    ) else $error("Undervoltage not detected");

    a_uv_mode_off: assert property (
        (CE && s.uv_func == UVF_OFF) |=> !UV_WARN
    ) else $error("Undervoltage warning while disabled");

    a_uv_release200: assert property (
        (CE && !s.sup400 && s.uv_func != UVF_OFF && UV_WARN
         && DC_BUS_V >= UV_DET_200 && DC_BUS_V < UV_REL_200) |=> UV_WARN
    ) else $error("Warning released below 280 V");

    a_uv_detect400: assert property (
        (CE && s.sup400 && s.uv_func != UVF_OFF && DC_BUS_V < 10'h190)
        |=> UV_WARN
    ) else $error("400 V supply warning missed");

    a_uv_hold_lim: assert property (
        (s.uv_st == UV_HOLD) |-> (lim_f <= s.uv_lim && lim_r <= s.uv_lim)
    ) else $error("Undervoltage limit not applied");

    a_ramp_time: assert property (
        (CE && s.uv_st == UV_HOLD && !s.uv_warn && s.rel_ms != 10'h0
         && s.mmax > s.uv_lim)
        |=> s.uv_st == UV_RAMP
            && s.ramp_t == 32'($past(s.rel_ms)) * 32'(CYC_PER_MS)
    ) else $error("Release ramp not started with set time");

    a_ramp_mono: assert property (
        (CE && s.uv_st == UV_RAMP && !s.uv_warn)
        |=> s.ramp_lim >= $past(s.ramp_lim)
            && s.ramp_lim <= $past(s.ramp_lim) + 10'h1
    ) else $error("Ramp not linear");

    a_method_rng: assert property (
        s.method <= METHOD_MAX
    ) else $error("Method out of range");

    a_lim_rng: assert property (
        s.int_fwd <= PCT_MAX && s.ext1 <= PCT_MAX && s.ext2 <= PCT_MAX
    ) else $error("Torque limit above 500 percent");

    a_warn_first: assert property (
        (s.warn_pct <= 10'h064 && s.warn_cur == OVL_START_PCT
         && s.derate == DERATE_NONE && $rose(MOTOR_OVL_ALARM))
        |-> MOTOR_OVL_WARN
    ) else $error("Alarm rose without warning");

endmodule

// ===== sim/svotl_plant.sv
module svotl_plant (
    // Clock
    input wire logic clk,
    // Targets set by the bench
    input wire logic [9:0] m_set,
    input wire logic [9:0] d_set,
    input wire logic [9:0] v_set,
    // Measurements seen by the drive
    output logic [9:0] m_cur,
    output logic [9:0] d_cur,
    output logic [9:0] bus_v
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        m_cur = 10'h0;
        d_cur = 10'h0;
        bus_v = 10'h12c;
    end
    // Sensors lag the power stage by one sample
    always @(posedge clk) begin
        m_cur <= m_set;
        d_cur <= d_set;
        bus_v <= v_set;
    end
endmodule

// ===== sim/tb_svotl_top.sv
module tb_svotl_top;
    import svotl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK, RST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdat, ctrl;
    logic EXT_FWD_SEL, EXT_REV_SEL, EMERG_STOP, TORQUE_LIMITED, UV_WARN;
    logic MOTOR_OVL_WARN, MOTOR_OVL_ALARM, DRIVE_OVL_WARN, DRIVE_OVL_ALARM;
    logic IRQ;
    logic signed [11:0] TORQUE_CMD, TORQUE_OUT;
    logic [9:0] MOTOR_CUR, DRIVE_CUR, DC_BUS_V, m_set, d_set, v_set;
    int err_count, check_count, tw, ta, td;
    logic [7:0] ra [11] = '{A_CTRL, A_INT_FWD, A_EXT2, A_ESTOP, A_MMAX,
        A_UV_LIM, A_UV_REL, A_WARN_PCT, A_DERATE, A_WARN_CUR, A_MASK};
    logic [31:0] rv [11] = '{32'h2, 32'h12c, 32'h12c, 32'h320, 32'h12c,
        32'h32, 32'h64, 32'h14, 32'h64, 32'h73, 32'h0};
    logic [11:0] fx [6] = '{12'h12c, 12'h64, 12'h64, 12'h64, 12'h64, 12'h1f4};
    logic [11:0] rx [6] = '{12'h12c, 12'h96, 12'h96, 12'h96, 12'h64, 12'h1f4};

    svotl_plant svotl_plant_i (.clk(MCLK), .m_set(m_set), .d_set(d_set),
        .v_set(v_set), .m_cur(MOTOR_CUR), .d_cur(DRIVE_CUR), .bus_v(DC_BUS_V));
    svotl_top #(.CYC_PER_MS(10), .OVL_ALARM_LVL(32'h3e8)) svotl_top_i (
        .MCLK(MCLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TORQUE_CMD(TORQUE_CMD),
        .MOTOR_CUR(MOTOR_CUR), .DRIVE_CUR(DRIVE_CUR), .DC_BUS_V(DC_BUS_V),
        .EXT_FWD_SEL(EXT_FWD_SEL), .EXT_REV_SEL(EXT_REV_SEL),
        .EMERG_STOP(EMERG_STOP), .TORQUE_OUT(TORQUE_OUT),
        .TORQUE_LIMITED(TORQUE_LIMITED), .UV_WARN(UV_WARN),
        .MOTOR_OVL_WARN(MOTOR_OVL_WARN), .MOTOR_OVL_ALARM(MOTOR_OVL_ALARM),
        .DRIVE_OVL_WARN(DRIVE_OVL_WARN), .DRIVE_OVL_ALARM(DRIVE_OVL_ALARM),
        .IRQ(IRQ));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        chk((v >= lo && v <= hi) ? lo : v, lo);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    // One APB transfer, held until PREADY is seen high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n == 20) begin
            err_count++;
            tally_and_finish();
        end
        rdat = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic tq(input logic signed [11:0] c, e, input logic l);
        @(posedge MCLK);
        TORQUE_CMD <= c;
        repeat (3) @(posedge MCLK);
        #1;
        chk(32'(TORQUE_OUT), 32'(e));
        chk({31'h0, TORQUE_LIMITED}, {31'h0, l});
    endtask
    task automatic uv(input logic [9:0] v, input logic e);
        @(posedge MCLK);
        v_set <= v;
        repeat (4) @(posedge MCLK);
        #1;
        chk({31'h0, UV_WARN}, {31'h0, e});
    endtask
    // Cycles from a cleared accumulator to motor warning, motor alarm and drive alarm
    task automatic ovl(input logic [9:0] m, input logic [9:0] d);
        wr(A_CTRL, ctrl | 32'h100);
        tw = -1;
        ta = -1;
        td = -1;
        m_set <= m;
        d_set <= d;
        for (int n = 0; n < 400 && (tw < 0 || ta < 0 || td < 0); n++) begin
            @(posedge MCLK);
            #1;
            if (tw < 0 && MOTOR_OVL_WARN === 1'b1) tw = n;
            if (ta < 0 && MOTOR_OVL_ALARM === 1'b1) ta = n;
            if (td < 0 && DRIVE_OVL_ALARM === 1'b1) td = n;
        end
        m_set <= 10'h0;
        d_set <= 10'h0;
    endtask

    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    initial begin
        RST = 1'b1;
        CE = 1'b1;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {TORQUE_CMD, EXT_FWD_SEL, EXT_REV_SEL, EMERG_STOP} = '0;
        m_set = 10'h0;
        d_set = 10'h0;
        v_set = 10'h12c;
        ctrl = 32'h2;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        for (int i = 0; i < 11; i++) rd(ra[i], rv[i]);
        wr(A_INT_REV, 32'h258);
        rd(A_INT_REV, 32'h1f4);
        wr(A_UV_REL, 32'h7d0);
        rd(A_UV_REL, 32'h3e8);
        wr(A_INT_REV, 32'h12c);
        rd(8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1);
        done("registers");
        CE <= 1'b0;
        tq(12'sd400, 12'sd0, 1'b0);
        @(posedge MCLK) CE <= 1'b1;
        tq(12'sd400, 12'sd300, 1'b1);
        tq(12'sd100, 12'sd100, 1'b0);
        tq(-12'sd400, -12'sd300, 1'b1);
        wr(A_MMAX, 32'h1f4);
        wr(A_EXT1, 32'h64);
        wr(A_EXT2, 32'h96);
        EXT_FWD_SEL <= 1'b1;
        EXT_REV_SEL <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(A_CTRL, 32'(i));
            tq(12'sd600, fx[i], 1'b1);
            tq(-12'sd600, -rx[i], 1'b1);
        end
        wr(A_CTRL, 32'h6);
        rd(A_CTRL, 32'h5);
        wr(A_MMAX, 32'hc8);
        tq(12'sd600, 12'sd200, 1'b1);
        wr(A_ESTOP, 32'h64);
        EMERG_STOP <= 1'b1;
        tq(12'sd600, 12'sd100, 1'b1);
        wr(A_MMAX, 32'h12c);
        EMERG_STOP <= 1'b0;
        done("torque limit");
        wr(A_MASK, 32'h20);
        bus(1'b0, A_STATUS, 32'h0);
        tq(12'sd100, 12'sd100, 1'b0);
        tq(12'sd400, 12'sd300, 1'b1);
        chk({31'h0, IRQ}, 32'h1);
        rd(A_STATUS, 32'h20);
        repeat (2) @(posedge MCLK);
        #1;
        chk({31'h0, IRQ}, 32'h0);
        done("interrupt");
        wr(A_UV_REL, 32'h1);
        ctrl = 32'h20;
        wr(A_CTRL, ctrl);
        uv(10'hbe, 1'b1);
        tq(12'sd400, 12'sd50, 1'b1);
        uv(10'hfa, 1'b1);
        uv(10'h118, 1'b0);
        repeat (10) @(posedge MCLK);
        #1;
        rng(TORQUE_OUT, 55, 65);
        for (tw = 0; tw < 600 && TORQUE_OUT !== 12'sd300; tw++)
            @(posedge MCLK);
        chk(32'(TORQUE_OUT), 32'h12c);
        ctrl = 32'h10;
        wr(A_CTRL, ctrl);
        uv(10'hbe, 1'b1);
        tq(12'sd400, 12'sd300, 1'b1);
        ctrl = 32'h0;
        wr(A_CTRL, ctrl);
        uv(10'hbe, 1'b0);
        uv(10'h258, 1'b0);
        ctrl = 32'h28;
        wr(A_CTRL, ctrl);
        uv(10'h186, 1'b1);
        uv(10'h226, 1'b1);
        uv(10'h230, 1'b0);
        done("undervoltage");
        TORQUE_CMD <= 12'sd0;
        ovl(10'd125, 10'd175);
        chk({31'h0, DRIVE_OVL_WARN}, 32'h1);
        rng(tw, 19, 25);
        rng(ta, 99, 106);
        rng(td, 4, 9);
        ovl(10'd175, 10'd125);
        rng(ta, 16, 22);
        wr(A_WARN_PCT, 32'h32);
        ovl(10'd125, 10'd175);
        rng(tw, 49, 55);
        wr(A_WARN_PCT, 32'h14);
        wr(A_WARN_CUR, 32'h78);
        ovl(10'd125, 10'd175);
        rng(tw, 39, 45);
        wr(A_WARN_CUR, 32'h73);
        wr(A_DERATE, 32'h32);
        ovl(10'd125, 10'd175);
        rng(ta, 15, 20);
        done("overload");
        tally_and_finish();
    end
endmodule
